// ===== rtl/thresh_compare.sv
// Purpose: Overtemperature limit and precise ORing switch threshold compare
// Assumes: Register port and converter results are on clk_i
// Notes:   Reading register exposes the upper eight bits of the reading
//          Writes to the reading or to unmapped addresses are dropped
//          Reserved precise selector code holds the precise flag low
//          Flags are registered and move one cycle after a sample
`timescale 1ns/1ps

module thresh_compare #(
    parameter int         TW        = thresh_pkg::TEMP_W,
    parameter int         DW        = 10,
    parameter logic [9:0] LEVEL_A_MV = 10'h00A,
    parameter logic [9:0] LEVEL_B_MV = 10'h014
) (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    // Register port
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic [7:0]    reg_wdata_i,
    input  wire logic          reg_rd_i,
    output logic [7:0]         reg_rdata_o,
    output logic               reg_rvalid_o,
    // Temperature converter result
    input  wire logic          temp_sense_valid_i,
    input  wire logic [TW-1:0] temp_sense_code_i,
    // Secondary current sense drop, signed millivolts
    input  wire logic          cs_drop_valid_i,
    input  wire logic signed [DW-1:0] cs_drop_mv_i,
    // Flags
    output logic               overtemp_flag_o,
    output logic               oring_switch_precise_flag_o
);

    // -----------------------------------------------------------------
    // Register writes
    // -----------------------------------------------------------------
    logic [7:0]    ot_limit_r;
    logic [7:0]    ot_limit_nxt;
    logic [7:0]    oring_ctrl_r;
    logic [7:0]    oring_ctrl_nxt;
    logic          wr_limit;
    logic          wr_ctrl;

    // Write strobe aimed at one register
    function automatic logic wr_hit(input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
        wr_hit = wr && (addr == target);
    endfunction

    // Only the limit and control registers take writes
    assign wr_limit = wr_hit(reg_wr_i, reg_addr_i, thresh_pkg::ADDR_OT_LIMIT);
    assign wr_ctrl  = wr_hit(reg_wr_i, reg_addr_i, thresh_pkg::ADDR_ORING_CTRL);

    // Next limit and control values
    always_comb
    begin
        ot_limit_nxt   = ot_limit_r;
        oring_ctrl_nxt = oring_ctrl_r;
        if (wr_limit)
            ot_limit_nxt = reg_wdata_i;
        if (wr_ctrl)
            oring_ctrl_nxt = reg_wdata_i;
    end

    // Limit and control registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ot_limit_r   <= thresh_pkg::OT_LIMIT_RESET;
            oring_ctrl_r <= thresh_pkg::ORING_CTRL_RESET;
        end
        else
        begin
            ot_limit_r   <= ot_limit_nxt;
            oring_ctrl_r <= oring_ctrl_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Reading capture
    // -----------------------------------------------------------------
    logic [TW-1:0] reading_r;
    logic [TW-1:0] reading_nxt;

    // Latest converter result, read only from the bus
    always_comb
    begin
        reading_nxt = reading_r;
        if (temp_sense_valid_i)
            reading_nxt = temp_sense_code_i;
    end

    // Reading register
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reading_r <= '0;
        else
            reading_r <= reading_nxt;
    end

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    logic [7:0]    rdata_r;
    logic [7:0]    rdata_nxt;
    logic          rvalid_r;
    logic          rvalid_nxt;

    // Byte view of the reading, top bits
    function automatic logic [7:0] reading_byte(input logic [TW-1:0] v);
        reading_byte = v[TW-1 -: 8];
    endfunction

    // Read mux; data holds until the next read
    always_comb
    begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                thresh_pkg::ADDR_TEMP_READING: rdata_nxt = reading_byte(reading_r);
                thresh_pkg::ADDR_OT_LIMIT:     rdata_nxt = ot_limit_r;
                thresh_pkg::ADDR_ORING_CTRL:   rdata_nxt = oring_ctrl_r;
                default:                       rdata_nxt = thresh_pkg::RDATA_ZERO;
            endcase
        end
    end

    // Read data and valid registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_r  <= thresh_pkg::RDATA_ZERO;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Register port outputs
    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // -----------------------------------------------------------------
    // Overtemperature compare
    // -----------------------------------------------------------------
    // Hysteresis comparator on each fresh reading
    ot_hyst_compare #(
        .W         (TW),
        .HYST      (thresh_pkg::HYST_CODES)
    ) u_ot (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .sample_i  (temp_sense_valid_i),
        .reading_i (temp_sense_code_i),
        .limit_i   (ot_limit_r),
        .flag_o    (overtemp_flag_o)
    );

    // -----------------------------------------------------------------
    // Precise ORing switch compare
    // -----------------------------------------------------------------
    logic [1:0]           precise_sel;
    logic signed [DW-1:0] precise_lvl;
    logic                 precise_ok;
    logic                 precise_r;
    logic                 precise_nxt;

    // Selector field of the control register
    assign precise_sel = oring_ctrl_r[thresh_pkg::PRECISE_SEL_MSB:thresh_pkg::PRECISE_SEL_LSB];

    // Threshold decode; reserved code disables the flag
    always_comb
    begin
        precise_ok  = 1'b1;
        case (precise_sel)
            thresh_pkg::SEL_ZERO_MV:  precise_lvl = '0;
            thresh_pkg::SEL_RESERVED:
            begin
                precise_lvl = '0;
                precise_ok  = 1'b0;
            end
            thresh_pkg::SEL_LEVEL_A:  precise_lvl = DW'(LEVEL_A_MV);
            thresh_pkg::SEL_LEVEL_B:  precise_lvl = DW'(LEVEL_B_MV);
            default:                  precise_lvl = '0;
        endcase
    end

    // -----------------------------------------------------------------
    // Precise ORing flag
    // -----------------------------------------------------------------

    // Flag follows each drop sample
    always_comb
    begin
        precise_nxt = precise_r;
        if (!precise_ok)
            precise_nxt = 1'b0;
        else if (cs_drop_valid_i)
            precise_nxt = (cs_drop_mv_i > precise_lvl);
    end

    // Precise flag register
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            precise_r <= 1'b0;
        else
            precise_r <= precise_nxt;
    end

    // Flag output straight from its register
    assign oring_switch_precise_flag_o = precise_r;

endmodule // thresh_compare

// ===== rtl/thresh_pkg.sv
// Purpose: Shared constants for the overtemperature and ORing threshold compare block
// Assumes: Readings come from on-chip converter logic on the same clock
// Notes:   All scale figures are held in microvolts or nanovolts
//
// Behaviour
// - Compare the 8-bit overtemperature limit with the temperature reading at 0x1A.
// - Raise the overtemperature flag when the reading falls below the limit.
// - One limit code step is worth a nominal 3.04 mV on the input scale.
// - The temperature reading spans 0 V to 1.55 V.
// - The overtemperature flag has 16 mV of hysteresis; the code rounds this up to 6 limit codes, 18.24 mV.
// - A 2-bit field selects the precise ORing switch drop threshold.
// - Field value 00 means 0 mV; value 01 is reserved and not written; a write of 01 is taken and holds the precise flag low.
package thresh_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_TEMP_READING = 8'h1A;
    localparam logic [7:0] ADDR_OT_LIMIT     = 8'h2F;
    localparam logic [7:0] ADDR_ORING_CTRL   = 8'h30;

    // Field layout of the ORing switch control register
    localparam int         PRECISE_SEL_MSB   = 7;
    localparam int         PRECISE_SEL_LSB   = 6;

    // Reset values
    localparam logic [7:0] OT_LIMIT_RESET    = 8'h03;
    localparam logic [7:0] ORING_CTRL_RESET  = 8'h00;
    localparam logic [7:0] RDATA_ZERO        = 8'h00;

    // Precise threshold selector codes
    localparam logic [1:0] SEL_ZERO_MV       = 2'h0;
    localparam logic [1:0] SEL_RESERVED      = 2'h1;
    localparam logic [1:0] SEL_LEVEL_A       = 2'h2;
    localparam logic [1:0] SEL_LEVEL_B       = 2'h3;

    // -----------------------------------------------------------------
    // Analog scale
    // -----------------------------------------------------------------
    localparam int LIMIT_LSB_NV   = 3040000;       // 3.04 mV per code
    localparam int TEMP_SPAN_UV   = 1550000;       // 1.55 V full span
    localparam int LIMIT_MIN_UV   = 9120;          // 9.12 mV lowest limit
    localparam int LIMIT_MAX_UV   = 760000;        // 760 mV highest limit
    localparam int HYST_UV        = 16000;         // 16 mV hysteresis

    // Reading width needed to cover the span at limit code resolution
    localparam int TEMP_CODES     = (TEMP_SPAN_UV * 1000) / LIMIT_LSB_NV;
    localparam int TEMP_W         = $clog2(TEMP_CODES + 1);

    // Hysteresis in codes, rounded up
    localparam int HYST_CODES     = (HYST_UV * 1000 + LIMIT_LSB_NV - 1) / LIMIT_LSB_NV;

    // Lowest and highest legal limit codes
    localparam int LIMIT_MIN_CODE = (LIMIT_MIN_UV * 1000) / LIMIT_LSB_NV;
    localparam int LIMIT_MAX_CODE = (LIMIT_MAX_UV * 1000) / LIMIT_LSB_NV;

endpackage

// ===== rtl/ot_hyst_compare.sv
// Purpose: Hysteresis comparator for the overtemperature flag
// Assumes: Reading and limit are in the same code units
// Notes:   Flag sets below limit, clears above limit plus margin
`timescale 1ns/1ps

module ot_hyst_compare #(
    parameter int W      = thresh_pkg::TEMP_W,
    parameter int HYST   = thresh_pkg::HYST_CODES
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         sample_i,
    input  wire logic [W-1:0] reading_i,
    input  wire logic [7:0]   limit_i,
    output logic              flag_o
);

    logic         flag_r;
    logic         flag_nxt;
    logic [W:0]   release_lvl;
    logic [W:0]   reading_ext;

    // Limit plus margin, one bit wider so it never wraps
    assign release_lvl = (W+1)'(limit_i) + (W+1)'(HYST);
    assign reading_ext = {1'b0, reading_i};

    // Set on low reading, clear on reading above release level
    always_comb
    begin
        flag_nxt = flag_r;
        if (sample_i)
        begin
            if (reading_ext < (W+1)'(limit_i))
                flag_nxt = 1'b1;
            else if (reading_ext > release_lvl)
                flag_nxt = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign flag_o = flag_r;

endmodule // ot_hyst_compare

// ===== bench/thresh_compare_props.sv
// Purpose: Port checker for thresh_compare
// Assumes: Hysteresis of six codes, levels 10 and 20 mV
// Notes:   Shadows limit and selector from register writes
`timescale 1ns/1ps
module thresh_props #(
    parameter int TW = 9,
    parameter int DW = 10
) (
    input wire logic                 clk_i,
    input wire logic                 nrst_i,
    input wire logic [7:0]           reg_addr_i,
    input wire logic                 reg_wr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic                 reg_rd_i,
    input wire logic [7:0]           reg_rdata_o,
    input wire logic                 reg_rvalid_o,
    input wire logic                 temp_sense_valid_i,
    input wire logic [TW-1:0]        temp_sense_code_i,
    input wire logic                 cs_drop_valid_i,
    input wire logic signed [DW-1:0] cs_drop_mv_i,
    input wire logic                 overtemp_flag_o,
    input wire logic                 oring_switch_precise_flag_o
);
    logic [7:0] lim_r;
    logic [1:0] sel_r;
    logic       tv;
    logic [9:0] c;
    assign tv = temp_sense_valid_i;
    assign c = 10'(temp_sense_code_i);
    // Shadow registers
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i) lim_r <= 8'h03;
        else if (reg_wr_i && reg_addr_i == 8'h2F) lim_r <= reg_wdata_i;
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i) sel_r <= 2'h0;
        else if (reg_wr_i && reg_addr_i == 8'h30) sel_r <= reg_wdata_i[7:6];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rv; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read valid missing");
    property p_nrv; !reg_rd_i |=> !reg_rvalid_o; endproperty
    a_nrv: assert property (p_nrv) else $error("stray read valid");
    property p_rdl; reg_rd_i && reg_addr_i == 8'h2F |=> reg_rdata_o == $past(lim_r); endproperty
    a_rdl: assert property (p_rdl) else $error("limit readback");
    property p_set; tv && c < lim_r |=> overtemp_flag_o; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_clr; tv && c > lim_r + 6 |=> !overtemp_flag_o; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_hys; tv && c >= lim_r && c <= lim_r + 6 |=> $stable(overtemp_flag_o); endproperty
    a_hys: assert property (p_hys) else $error("flag moved in band");
    property p_idl; !tv |=> $stable(overtemp_flag_o); endproperty
    a_idl: assert property (p_idl) else $error("flag moved idle");
    property p_zero;
        cs_drop_valid_i && sel_r == 2'h0 |=>
            oring_switch_precise_flag_o == ($past(cs_drop_mv_i) > 0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero level compare");
    property p_rsv; sel_r == 2'h1 |=> !oring_switch_precise_flag_o; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved not low");
    c_set: cover property (tv && c < lim_r);
    c_clr: cover property (tv && c > lim_r + 6 && overtemp_flag_o);
    c_lvb: cover property (sel_r == 2'h3 && cs_drop_valid_i && cs_drop_mv_i > 20);
endmodule // thresh_props
bind thresh_compare thresh_props #(.TW(TW), .DW(DW)) u_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .temp_sense_valid_i(temp_sense_valid_i),
    .temp_sense_code_i(temp_sense_code_i), .cs_drop_valid_i(cs_drop_valid_i),
    .cs_drop_mv_i(cs_drop_mv_i), .overtemp_flag_o(overtemp_flag_o),
    .oring_switch_precise_flag_o(oring_switch_precise_flag_o));

// ===== bench/sense_model.sv
// Purpose: Temperature converter and sense drop source
// Assumes: Driven 1 ns after clk_i rises
// Notes:   Idle code line shows inverse of last value
`timescale 1ns/1ps
module sense_model (
    input  wire logic        clk_i,
    output logic             tval_o,
    output logic [8:0]       tcode_o,
    output logic             dval_o,
    output logic signed [9:0] dmv_o
);
    initial {tval_o, tcode_o, dval_o, dmv_o} = 21'h0;
    // One converter sample, clamped to the 1.55 V span
    task automatic temp(input int cd);
        @(posedge clk_i) #1;
        tval_o = 1'b1;
        tcode_o = 9'(cd > 509 ? 509 : cd);
        @(posedge clk_i) #1;
        tval_o = 1'b0;
        tcode_o = ~tcode_o;
    endtask
    // One secondary sense drop sample
    task automatic drop(input int dv);
        @(posedge clk_i) #1;
        dval_o = 1'b1;
        dmv_o = 10'(dv);
        @(posedge clk_i) #1;
        dval_o = 1'b0;
        dmv_o = ~dmv_o;
    endtask
endmodule // sense_model

// ===== bench/tb.sv
// Purpose: Self-checking bench for thresh_compare
// Assumes: Flags settle one cycle after a sample
// Notes:   Reference model in integers
`timescale 1ns/1ps
module tb;
    logic clk_i = 0, nrst_i = 0, wr = 0, rd = 0, rv, tv, dv, otf, orf;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [8:0] tc;
    logic signed [9:0] dm;
    int fails = 0, cmp_count = 0, seed = 96, lim = 3, sel, flg = 0, ofl, cd, d, v;
    always #2.5 clk_i = ~clk_i;
    thresh_compare #(.TW(9)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .reg_rvalid_o(rv), .temp_sense_valid_i(tv), .temp_sense_code_i(tc),
        .cs_drop_valid_i(dv), .cs_drop_mv_i(dm), .overtemp_flag_o(otf),
        .oring_switch_precise_flag_o(orf));
    sense_model u_snsr (.clk_i(clk_i), .tval_o(tv), .tcode_o(tc), .dval_o(dv), .dmv_o(dm));
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin fails++; $display("MISMATCH %0t read got %h exp %h", $time, g, e); end
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin fails++; $display("MISMATCH %0t flag got %b exp %b", $time, g, e); end
    endtask
    task automatic test_done;
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] dt);
        @(posedge clk_i) #1;
        addr = a; wd = dt; wr = 1;
        @(posedge clk_i) #1;
        wr = 0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i) #1;
        addr = a; rd = 1;
        @(posedge clk_i) #1;
        rd = 0;
        cmp_reg({7'h00, rv}, 8'h01);
        cmp_reg(rdat, e);
    endtask
    initial begin #100000; fails++; test_done; end
    // Reset, reset values, then random sweeps
    initial begin
        repeat (16) @(posedge clk_i);
        #1 nrst_i = 1;
        rd8(8'h2F, 8'h03);
        rd8(8'h30, 8'h00);
        rd8(8'h55, 8'h00);
        for (int i = 0; i < 80; i++) begin
            if (i % 4 == 0) lim = 3 + {$random(seed)} % 248;
            if (i % 4 == 0) wr8(8'h2F, 8'(lim));
            cd = lim + $random(seed) % 12;
            if (cd < 0) cd = 0;
            u_snsr.temp(cd);
            if (cd < lim) flg = 1;
            else if (cd > lim + 6) flg = 0;
            cmp_flag(otf, 1'(flg));
            wr8(8'h1A, 8'hFF);
            rd8(8'h1A, 8'(cd >> 1));
            rd8(8'h2F, 8'(lim));
            sel = (i % 3 == 0) ? 0 : i % 3 + 1;
            v = (sel << 6) | ({$random(seed)} % 64);
            wr8(8'h30, 8'(v));
            rd8(8'h30, 8'(v));
            d = $random(seed) % 30;
            u_snsr.drop(d);
            ofl = d > (sel == 0 ? 0 : sel == 2 ? 10 : 20);
            cmp_flag(orf, 1'(ofl));
        end
        test_done;
    end
endmodule // tb
